// *** common/crf_pkg.sv ***
package crf_pkg;

  // ****************************************************************
  // Register indices and field positions
  // ****************************************************************
  localparam logic [2:0] GPR_ACCUM  = 3'h0;
  localparam logic [2:0] GPR_COUNT  = 3'h1;
  localparam logic [2:0] GPR_DATA   = 3'h2;
  localparam logic [2:0] GPR_BASE   = 3'h3;
  localparam logic [2:0] GPR_STACK  = 3'h4;
  localparam logic [2:0] GPR_BASEP  = 3'h5;
  localparam logic [2:0] GPR_SRCIDX = 3'h6;
  localparam logic [2:0] GPR_DSTIDX = 3'h7;
  localparam logic [2:0] GPR_SPLIT_LIMIT = 3'h4;

  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE  = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA  = 2'h3;

  localparam int FLG_CARRY = 0;
  localparam int FLG_PAR   = 2;
  localparam int FLG_AUX   = 4;
  localparam int FLG_ZERO  = 6;
  localparam int FLG_SIGN  = 7;
  localparam int FLG_TRACE = 8;
  localparam int FLG_INTEN = 9;
  localparam int FLG_DIR   = 10;
  localparam int FLG_OVF   = 11;
  localparam int AUX_BIT   = 4;

  localparam logic [15:0] FLAGS_WRITABLE = 16'h0fd5;
  localparam logic [15:0] FLAGS_STATUS   = 16'h08d5;
  localparam logic [15:0] FLAGS_RSVD_VAL = 16'h0000;
  localparam logic [15:0] RESET_WORD     = 16'h0000;

  localparam logic [15:0] IO_RSVD_LO = 16'h00f8;
  localparam logic [15:0] IO_RSVD_HI = 16'h00ff;

  // ****************************************************************
  // Access kinds and bus map
  // ****************************************************************
  typedef enum logic [1:0] {MEM_FETCH, MEM_DATA, MEM_STACK} crf_mem_kind_e;
  typedef enum logic [1:0] {EA_NONE, EA_BASE, EA_BASEP} crf_base_sel_e;
  typedef enum logic [1:0] {IX_NONE, IX_SRC, IX_DST} crf_idx_sel_e;

  localparam logic [7:0] OFS_GPR_BASE = 8'h00;
  localparam logic [7:0] OFS_SEG_BASE = 8'h20;
  localparam logic [7:0] OFS_IP       = 8'h30;
  localparam logic [7:0] OFS_FLAGS    = 8'h34;
  localparam logic [7:0] OFS_MEMADDR  = 8'h38;
  localparam logic [7:0] OFS_IOADDR   = 8'h3c;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage

// *** design/crf_core.sv ***
// Overview of operation
// [RULE1] Eight word registers, four split into bytes.
// [RULE2] Base/index registers form operand offsets.
// [RULE3] Stack accesses use stack pointer, stack segment.
// [RULE4] Four segment selectors: code, data, extra, stack.
// [RULE5] Instruction pointer offsets next instruction from code.
// [RULE6] Flag word status and control bit layout.
// [RULE7] Flags set, cleared, kept or undefined per instruction.
// [RULE8] Overflow set when signed result does not fit.
// [RULE9] Direction flag: decrement when set, else increment.
// [RULE10] Interrupt-enable gates maskable interrupts.
// [RULE11] Trace interrupt after instructions, then clears trace.
// [RULE12] Sign flag equals result high bit.
// [RULE13] Zero flag set on zero result.
// [RULE14] Aux carry from low nibble carry or borrow.
// [RULE15] Parity set on even ones in low byte.
// [RULE16] Carry set on high bit carry or borrow.
// [RULE17] Segments span 64K; segment plus offset addressing.
// [RULE18] Physical address is segment shifted four plus offset.
// [RULE19] I/O space of byte or word ports.
// [RULE20] Port address from immediate byte or data word.
// [RULE21] Immediate port address zero-extended, high byte low.
// [RULE22] Ports F8h to FFh reserved for software.
// [RULE23] Reserved flag bits read fixed, ignore writes.
`timescale 1ns/1ps
module crf_core (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rstn_i,
  // Execution unit: register writes and reads.
  input  wire logic                  ex_wr_i,
  input  wire logic [2:0]            ex_wr_idx_i,
  input  wire logic [1:0]            ex_wr_be_i,
  input  wire logic [15:0]           ex_wr_data_i,
  input  wire logic [2:0]            ex_rd_idx_i,
  output logic      [15:0]           ex_rd_data_o,
  input  wire logic                  seg_wr_i,
  input  wire logic [1:0]            seg_wr_idx_i,
  input  wire logic [15:0]           seg_wr_data_i,
  input  wire logic                  ip_load_i,
  input  wire logic [15:0]           ip_load_val_i,
  input  wire logic                  ip_adv_i,
  input  wire logic [2:0]            ip_adv_len_i,
  output logic      [15:0]           ip_o,
  // Flag updates.
  input  wire logic                  alu_upd_i,
  input  wire logic                  alu_word_i,
  input  wire logic                  alu_sub_i,
  input  wire logic                  alu_cin_i,
  input  wire logic [15:0]           alu_a_i,
  input  wire logic [15:0]           alu_b_i,
  input  wire logic [15:0]           alu_mask_i,
  output logic      [15:0]           alu_result_o,
  input  wire logic [15:0]           flag_set_i,
  input  wire logic [15:0]           flag_clr_i,
  input  wire logic                  flag_load_i,
  input  wire logic [15:0]           flag_load_val_i,
  output logic      [15:0]           flags_o,
  // Interrupt and trace.
  input  wire logic                  intr_req_i,
  output logic                       intr_take_o,
  input  wire logic                  instr_done_i,
  output logic                       trace_req_o,
  input  wire logic                  trace_push_done_i,
  // String index stepping.
  input  wire logic                  str_step_i,
  input  wire logic                  str_word_i,
  input  wire logic                  str_src_i,
  input  wire logic                  str_dst_i,
  // Memory address generation.
  input  wire logic                  mem_req_i,
  input  wire crf_pkg::crf_mem_kind_e mem_kind_i,
  input  wire logic [1:0]            mem_seg_sel_i,
  input  wire crf_pkg::crf_base_sel_e mem_base_sel_i,
  input  wire crf_pkg::crf_idx_sel_e mem_idx_sel_i,
  input  wire logic [15:0]           mem_disp_i,
  output logic                       mem_valid_o,
  output logic      [15:0]           mem_seg_o,
  output logic      [15:0]           mem_off_o,
  output logic      [19:0]           mem_addr_o,
  // I/O port address generation.
  input  wire logic                  io_req_i,
  input  wire logic                  io_use_dx_i,
  input  wire logic [7:0]            io_imm_i,
  input  wire logic                  io_word_i,
  output logic                       io_valid_o,
  output logic      [15:0]           io_addr_o,
  output logic                       io_word_o,
  output logic                       io_rsvd_o,
  // AXI4-Lite slave.
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic      [1:0]            s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  import crf_pkg::*;

  logic [15:0] gpr_reg [8];
  logic [15:0] seg_reg [4];
  logic [15:0] ip_reg;
  logic [15:0] flags_reg;
  logic        trace_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [15:0] wdata_reg;
  logic [1:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wr_fire;
  logic [15:0] str_delta;

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  // Address and data are latched separately, so either may come first.
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign wr_fire       = aw_hold_reg && w_hold_reg && !bvalid_reg;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= RESET_WORD;
      wstrb_reg   <= 2'b00;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[15:0];
        wstrb_reg  <= s_axi_wstrb[1:0];
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (awaddr_reg > OFS_FLAGS || awaddr_reg[1:0] != 2'b00) ?
                       RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  function automatic logic [15:0] merge_bytes(input logic [15:0] old_val);
    merge_bytes = {wstrb_reg[1] ? wdata_reg[15:8] : old_val[15:8],
                   wstrb_reg[0] ? wdata_reg[7:0]  : old_val[7:0]};
  endfunction

  // ****************************************************************
  // General registers
  // ****************************************************************
  // Execution-unit writes outrank a bus write landing in the same cycle.
  assign str_delta = str_word_i ? 16'h0002 : 16'h0001;

  for (genvar g = 0; g < 8; g++) begin : g_gpr
    localparam logic [2:0] IDX = 3'(g);
    logic [1:0] be_eff;
    logic       step_me;
    assign be_eff  = (IDX < GPR_SPLIT_LIMIT) ? ex_wr_be_i : 2'b11; // see [RULE1]
    assign step_me = str_step_i && ((IDX == GPR_SRCIDX && str_src_i) ||
                                    (IDX == GPR_DSTIDX && str_dst_i));
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        gpr_reg[g] <= RESET_WORD;
      end else if (ex_wr_i && ex_wr_idx_i == IDX) begin
        if (be_eff[1]) gpr_reg[g][15:8] <= ex_wr_data_i[15:8]; // see [RULE1]
        if (be_eff[0]) gpr_reg[g][7:0]  <= ex_wr_data_i[7:0];
      end else if (step_me) begin
        gpr_reg[g] <= flags_reg[FLG_DIR] ? gpr_reg[g] - str_delta
                                         : gpr_reg[g] + str_delta; // see [RULE9]
      end else if (wr_fire && awaddr_reg == OFS_GPR_BASE + {3'b000, IDX, 2'b00}) begin
        gpr_reg[g] <= merge_bytes(gpr_reg[g]);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) ex_rd_data_o <= RESET_WORD;
    else         ex_rd_data_o <= gpr_reg[ex_rd_idx_i];
  end

  // ****************************************************************
  // Segment selectors and instruction pointer
  // ****************************************************************
  for (genvar s = 0; s < 4; s++) begin : g_seg
    localparam logic [1:0] SIDX = 2'(s);
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        seg_reg[s] <= RESET_WORD;
      end else if (seg_wr_i && seg_wr_idx_i == SIDX) begin
        seg_reg[s] <= seg_wr_data_i; // see [RULE4]
      end else if (wr_fire && awaddr_reg == OFS_SEG_BASE + {4'h0, SIDX, 2'b00}) begin
        seg_reg[s] <= merge_bytes(seg_reg[s]);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ip_reg <= RESET_WORD;
    end else if (ip_load_i) begin
      ip_reg <= ip_load_val_i;
    end else if (ip_adv_i) begin
      ip_reg <= ip_reg + {13'h0000, ip_adv_len_i}; // see [RULE5]
    end else if (wr_fire && awaddr_reg == OFS_IP) begin
      ip_reg <= merge_bytes(ip_reg);
    end
  end
  assign ip_o = ip_reg;

  // ****************************************************************
  // Flag computation and flag word
  // ****************************************************************
  logic [15:0] b_eff;
  logic        c0;
  logic [16:0] sum_w;
  logic [8:0]  sum_b;
  logic [15:0] res;
  logic        msb_a;
  logic        msb_b;
  logic        msb_r;
  logic [15:0] alu_flags;

  // Subtraction runs as a + ~b + 1 - borrow, so carry out inverts into borrow.
  assign b_eff = alu_sub_i ? ~alu_b_i : alu_b_i;
  assign c0    = alu_sub_i ? !alu_cin_i : alu_cin_i;
  assign sum_w = {1'b0, alu_a_i} + {1'b0, b_eff} + {16'h0000, c0};
  assign sum_b = {1'b0, alu_a_i[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, c0};
  assign res   = alu_word_i ? sum_w[15:0] : {8'h00, sum_b[7:0]};
  assign msb_a = alu_word_i ? alu_a_i[15] : alu_a_i[7];
  assign msb_b = alu_word_i ? b_eff[15] : b_eff[7];
  assign msb_r = alu_word_i ? res[15] : res[7];

  always_comb begin
    alu_flags            = RESET_WORD;
    alu_flags[FLG_CARRY] = (alu_word_i ? sum_w[16] : sum_b[8]) ^ alu_sub_i; // see [RULE16]
    alu_flags[FLG_PAR]   = ~^res[7:0]; // see [RULE15]
    alu_flags[FLG_AUX]   = alu_a_i[AUX_BIT] ^ alu_b_i[AUX_BIT] ^ res[AUX_BIT]; // see [RULE14]
    alu_flags[FLG_ZERO]  = (res == RESET_WORD); // see [RULE13]
    alu_flags[FLG_SIGN]  = msb_r; // see [RULE12]
    alu_flags[FLG_OVF]   = (msb_a == msb_b) && (msb_r != msb_a); // see [RULE8]
  end

  // Lowest to highest priority: bus, flag load, set/clear, result, trace.
  // Flags outside the result mask keep their value, which also serves as the
  // value of any flag left undefined by an instruction.
  logic [15:0] flags_next;
  logic [15:0] upd_mask;
  assign upd_mask = alu_mask_i & FLAGS_STATUS;

  always_comb begin
    flags_next = flags_reg;
    if (wr_fire && awaddr_reg == OFS_FLAGS) flags_next = merge_bytes(flags_reg);
    if (flag_load_i) flags_next = flag_load_val_i;
    flags_next = (flags_next | (flag_set_i & FLAGS_WRITABLE)) &
                 ~(flag_clr_i & FLAGS_WRITABLE); // see [RULE7]
    if (alu_upd_i) flags_next = (flags_next & ~upd_mask) | (alu_flags & upd_mask); // see [RULE7]
    if (trace_push_done_i) flags_next[FLG_TRACE] = 1'b0; // see [RULE11]
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_reg <= FLAGS_RSVD_VAL;
    end else begin
      flags_reg <= (flags_next & FLAGS_WRITABLE) | FLAGS_RSVD_VAL; // see [RULE6] [RULE23]
    end
  end
  assign flags_o = flags_reg;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)        alu_result_o <= RESET_WORD;
    else if (alu_upd_i) alu_result_o <= res;
  end

  // ****************************************************************
  // Interrupt gating and trace request
  // ****************************************************************
  assign intr_take_o = intr_req_i && flags_reg[FLG_INTEN]; // see [RULE10]

  // A new instruction completion wins over the acknowledge in the same cycle.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trace_reg <= 1'b0;
    end else if (instr_done_i && flags_reg[FLG_TRACE]) begin
      trace_reg <= 1'b1; // see [RULE11]
    end else if (trace_push_done_i) begin
      trace_reg <= 1'b0;
    end
  end
  assign trace_req_o = trace_reg;

  // ****************************************************************
  // Memory and I/O address generation
  // ****************************************************************
  logic [15:0] ea_base;
  logic [15:0] ea_idx;
  logic [15:0] off_sel;
  logic [15:0] seg_sel;

  always_comb begin
    ea_base = RESET_WORD;
    ea_idx  = RESET_WORD;
    if (mem_base_sel_i == EA_BASE) ea_base = gpr_reg[GPR_BASE]; // see [RULE2]
    else if (mem_base_sel_i == EA_BASEP) ea_base = gpr_reg[GPR_BASEP];
    if (mem_idx_sel_i == IX_SRC) ea_idx = gpr_reg[GPR_SRCIDX];
    else if (mem_idx_sel_i == IX_DST) ea_idx = gpr_reg[GPR_DSTIDX];
    case (mem_kind_i)
      MEM_FETCH: begin
        seg_sel = seg_reg[SEG_CODE]; // see [RULE5]
        off_sel = ip_reg;
      end
      MEM_STACK: begin
        seg_sel = seg_reg[SEG_STACK]; // see [RULE3]
        off_sel = gpr_reg[GPR_STACK];
      end
      default: begin
        seg_sel = seg_reg[mem_seg_sel_i]; // see [RULE17]
        off_sel = ea_base + ea_idx + mem_disp_i; // see [RULE2]
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_valid_o <= 1'b0;
      mem_seg_o   <= RESET_WORD;
      mem_off_o   <= RESET_WORD;
      mem_addr_o  <= 20'h0_0000;
    end else begin
      mem_valid_o <= mem_req_i;
      if (mem_req_i) begin
        mem_seg_o  <= seg_sel;
        mem_off_o  <= off_sel;
        mem_addr_o <= {seg_sel, 4'h0} + {4'h0, off_sel}; // see [RULE18]
      end
    end
  end

  logic [15:0] io_sel;
  assign io_sel = io_use_dx_i ? gpr_reg[GPR_DATA] : {8'h00, io_imm_i}; // see [RULE20] [RULE21]

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      io_valid_o <= 1'b0;
      io_addr_o  <= RESET_WORD;
      io_word_o  <= 1'b0;
      io_rsvd_o  <= 1'b0;
    end else begin
      io_valid_o <= io_req_i;
      if (io_req_i) begin
        io_addr_o <= io_sel;
        io_word_o <= io_word_i; // see [RULE19]
        io_rsvd_o <= io_sel >= IO_RSVD_LO && io_sel <= IO_RSVD_HI; // see [RULE22]
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  logic [15:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_word = RESET_WORD;
    rd_ok   = s_axi_araddr[1:0] == 2'b00;
    if (s_axi_araddr < OFS_SEG_BASE) rd_word = gpr_reg[s_axi_araddr[4:2]];
    else if (s_axi_araddr < OFS_IP) rd_word = seg_reg[s_axi_araddr[3:2]];
    else if (s_axi_araddr == OFS_IP) rd_word = ip_reg;
    else if (s_axi_araddr == OFS_FLAGS) rd_word = flags_reg;
    else if (s_axi_araddr == OFS_MEMADDR) rd_word = mem_off_o;
    else if (s_axi_araddr == OFS_IOADDR) rd_word = io_addr_o;
    else rd_ok = 1'b0;
  end

  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= (s_axi_araddr == OFS_MEMADDR) ? {12'h000, mem_addr_o} :
                    (rd_ok ? {16'h0000, rd_word} : 32'h0000_0000);
      rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_phys_addr_sum: assert property ( // see [RULE18]
    mem_valid_o |-> mem_addr_o == {mem_seg_o, 4'h0} + {4'h0, mem_off_o})
    else $error("physical address is not segment times 16 plus offset");
  a_stack_seg_fixed: assert property ( // see [RULE3]
    mem_req_i && mem_kind_i == MEM_STACK |=>
      mem_seg_o == $past(seg_reg[SEG_STACK]) && mem_off_o == $past(gpr_reg[GPR_STACK]))
    else $error("stack access did not use stack segment and pointer");
  a_fetch_code_ip: assert property ( // see [RULE5]
    mem_req_i && mem_kind_i == MEM_FETCH |=>
      mem_seg_o == $past(seg_reg[SEG_CODE]) && mem_off_o == $past(ip_reg))
    else $error("fetch did not use code segment and instruction pointer");
  a_io_imm_zext: assert property ( // see [RULE21]
    io_req_i && !io_use_dx_i |=> io_valid_o && io_addr_o == {8'h00, $past(io_imm_i)})
    else $error("immediate port address not zero extended");
  a_io_from_dx: assert property ( // see [RULE20]
    io_req_i && io_use_dx_i |=> io_addr_o == $past(gpr_reg[GPR_DATA]))
    else $error("port address does not match data word");
  a_rsvd_flags_fixed: assert property ( // see [RULE23]
    (flags_o & ~FLAGS_WRITABLE) == FLAGS_RSVD_VAL)
    else $error("reserved flag bits changed");
  a_intr_gate_ie: assert property ( // see [RULE10]
    intr_req_i && !flags_o[FLG_INTEN] |-> !intr_take_o)
    else $error("maskable interrupt taken while disabled");
  a_trace_clear_after: assert property ( // see [RULE11]
    trace_push_done_i |=> !flags_o[FLG_TRACE])
    else $error("trace flag not cleared after push");
  a_zero_parity_flags: assert property ( // see [RULE13] [RULE15]
    alu_upd_i && alu_mask_i[FLG_ZERO] && alu_mask_i[FLG_PAR] |=>
      flags_o[FLG_ZERO] == (alu_result_o == RESET_WORD) &&
      flags_o[FLG_PAR] == ~^alu_result_o[7:0])
    else $error("zero or parity flag disagrees with result");
  a_string_dst_step: assert property ( // see [RULE9]
    str_step_i && str_dst_i && !str_word_i && !(ex_wr_i && ex_wr_idx_i == GPR_DSTIDX) |=>
      gpr_reg[GPR_DSTIDX] == $past(gpr_reg[GPR_DSTIDX]) +
        ($past(flags_reg[FLG_DIR]) ? 16'hffff : 16'h0001))
    else $error("destination index stepped the wrong way");
  a_byte_half_keep: assert property ( // see [RULE1]
    ex_wr_i && ex_wr_idx_i < GPR_SPLIT_LIMIT && ex_wr_be_i == 2'b01 |=>
      gpr_reg[$past(ex_wr_idx_i)][15:8] == $past(gpr_reg[ex_wr_idx_i][15:8]))
    else $error("low byte write disturbed high byte");

  c_trace_round: cover property (instr_done_i && flags_o[FLG_TRACE] ##[1:20] trace_push_done_i);
  c_stack_access: cover property (mem_req_i && mem_kind_i == MEM_STACK ##1 mem_valid_o);
  c_bus_write: cover property (wr_fire ##1 s_axi_bvalid);
  c_io_reserved: cover property (io_valid_o && io_rsvd_o);

endmodule // crf_core

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import crf_pkg::*;
  // ****
  // Signals
  // ****
  logic        clk_sys_i=0, rstn_i=0, ex_wr_i=0, seg_wr_i=0, ip_load_i=0, ip_adv_i=0;
  logic        alu_upd_i=0, alu_word_i=0, alu_sub_i=0, alu_cin_i=0, flag_load_i=0;
  logic        intr_req_i=0, instr_done_i=0, trace_push_done_i=0, str_step_i=0;
  logic        str_word_i=0, str_src_i=0, str_dst_i=0, mem_req_i=0, io_req_i=0;
  logic        io_use_dx_i=0, io_word_i=0, s_axi_awvalid=0, s_axi_wvalid=0;
  logic        s_axi_bready=0, s_axi_arvalid=0, s_axi_rready=0, pa, pw;
  logic [2:0]  ex_wr_idx_i=0, ex_rd_idx_i=0, ip_adv_len_i=0;
  logic [1:0]  ex_wr_be_i=0, seg_wr_idx_i=0, mem_seg_sel_i=0, rs;
  logic [15:0] ex_wr_data_i=0, seg_wr_data_i=0, ip_load_val_i=0, alu_a_i=0, alu_b_i=0;
  logic [15:0] alu_mask_i=0, flag_set_i=0, flag_clr_i=0, flag_load_val_i=0, mem_disp_i=0;
  logic [7:0]  io_imm_i=0, s_axi_awaddr=0, s_axi_araddr=0;
  logic [3:0]  s_axi_wstrb=0;
  logic [31:0] s_axi_wdata=0, s_axi_rdata, rd;
  crf_mem_kind_e mem_kind_i=MEM_FETCH;
  crf_base_sel_e mem_base_sel_i=EA_BASE;
  crf_idx_sel_e  mem_idx_sel_i=IX_SRC;
  logic [15:0] ex_rd_data_o, ip_o, alu_result_o, flags_o, mem_seg_o, mem_off_o, io_addr_o;
  logic        intr_take_o, trace_req_o, mem_valid_o, io_valid_o, io_word_o, io_rsvd_o;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [19:0] mem_addr_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          fail_count=0, tests_run=0, cyc=0;
  crf_core uut (.*);
  always #12.5 clk_sys_i = ~clk_sys_i;
  // ****
  // Tasks
  // ****
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task nx;
    @(posedge clk_sys_i);
  endtask
  // Address and data are offered together; each is dropped once taken.
  task wr(input logic [7:0] a, input logic [31:0] d);
    nx; s_axi_awaddr<=a; s_axi_wdata<=d; s_axi_wstrb<=4'hf;
    s_axi_awvalid<=1; s_axi_wvalid<=1; s_axi_bready<=1; pa=1; pw=1;
    while (pa || pw) begin
      nx;
      if (pa && s_axi_awready) begin s_axi_awvalid<=0; pa=0; end
      if (pw && s_axi_wready) begin s_axi_wvalid<=0; pw=0; end
    end
    if (!s_axi_bvalid) do nx; while (!s_axi_bvalid);
    rs = s_axi_bresp; s_axi_bready<=0;
  endtask
  task rdr(input logic [7:0] a);
    nx; s_axi_araddr<=a; s_axi_arvalid<=1; s_axi_rready<=1;
    do nx; while (!s_axi_arready);
    s_axi_arvalid<=0;
    do nx; while (!s_axi_rvalid);
    rd = s_axi_rdata; rs = s_axi_rresp; s_axi_rready<=0;
  endtask
  task gw(input logic [2:0] i, input logic [1:0] b, input logic [15:0] d);
    nx; ex_wr_i<=1; ex_wr_idx_i<=i; ex_wr_be_i<=b; ex_wr_data_i<=d;
    nx; ex_wr_i<=0;
  endtask
  task sw(input logic [1:0] i, input logic [15:0] d);
    nx; seg_wr_i<=1; seg_wr_idx_i<=i; seg_wr_data_i<=d;
    nx; seg_wr_i<=0;
  endtask
  task mq(input crf_mem_kind_e k, input logic [19:0] e);
    nx; mem_req_i<=1; mem_kind_i<=k; mem_seg_sel_i<=SEG_DATA;
    nx; mem_req_i<=0; #1;
    chk({mem_valid_o, mem_addr_o}, {1'b1, e});
  endtask
  task io(input logic x, input logic [7:0] m, input logic [15:0] ea, input logic er);
    nx; io_req_i<=1; io_use_dx_i<=x; io_imm_i<=m; io_word_i<=x;
    nx; io_req_i<=0; #1;
    chk({io_valid_o, io_word_o, io_rsvd_o, io_addr_o}, {1'b1, x, er, ea});
  endtask
  task al(input logic [15:0] a, input logic [15:0] b, input logic [1:0] ws, input logic [15:0] f);
    nx; alu_upd_i<=1; alu_a_i<=a; alu_b_i<=b; alu_mask_i<=FLAGS_STATUS;
    {alu_word_i, alu_sub_i}<=ws;
    nx; alu_upd_i<=0; #1;
    chk(flags_o, f);
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test;
    end
  end
  initial begin
    repeat (6) nx;
    rstn_i<=1;
    rdr(OFS_FLAGS); chk(rd, 0);
    wr(OFS_FLAGS, 32'hffff_ffff); chk(rs, RESP_OKAY);
    rdr(OFS_FLAGS); chk(rd, 32'h0000_0fd5);
    nx; intr_req_i<=1; #1 chk(intr_take_o, 1);
    wr(OFS_FLAGS, 0); #1 chk(intr_take_o, 0);
    gw(GPR_ACCUM, 2'h3, 16'h1234); gw(GPR_ACCUM, 2'h1, 16'h00ab);
    rdr(OFS_GPR_BASE); chk(rd, 32'h0000_12ab);
    #1 chk(ex_rd_data_o, 32'h0000_12ab);
    gw(GPR_BASE, 2'h3, 16'h0008); gw(GPR_SRCIDX, 2'h3, 16'h0008); gw(GPR_STACK, 2'h3, 16'h0022);
    sw(SEG_DATA, 16'hffff); sw(SEG_STACK, 16'h12a4); sw(SEG_CODE, 16'h1000);
    mq(MEM_DATA, 20'h0_0000);
    mq(MEM_STACK, 20'h1_2a62);
    chk({mem_seg_o, mem_off_o}, 32'h12a4_0022);
    rdr(OFS_MEMADDR); chk(rd, 32'h0001_2a62);
    gw(GPR_DATA, 2'h3, 16'habcd); io(1, 8'h12, 16'habcd, 0);
    io(0, 8'hf8, 16'h00f8, 1);
    al(16'h007f, 16'h0001, 2'h0, 16'h0890);
    al(16'h00ff, 16'h0001, 2'h0, 16'h0055);
    al(16'h0000, 16'h0001, 2'h3, 16'h0095);
    chk(alu_result_o, 32'h0000_ffff);
    al(16'h0003, 16'h0000, 2'h0, 16'h0004);
    nx; flag_set_i<=16'h0400;
    nx; flag_set_i<=0; str_step_i<=1; str_word_i<=1; str_src_i<=1;
    nx; str_word_i<=0; str_src_i<=0; str_dst_i<=1;
    nx; str_step_i<=0;
    rdr(OFS_GPR_BASE + 8'h18); chk(rd, 32'h0000_0006);
    rdr(OFS_GPR_BASE + 8'h1c); chk(rd, 32'h0000_ffff);
    nx; ip_load_i<=1; ip_load_val_i<=16'h0100;
    nx; ip_load_i<=0; ip_adv_i<=1; ip_adv_len_i<=3'h3;
    nx; ip_adv_i<=0; #1 chk(ip_o, 32'h0000_0103);
    mq(MEM_FETCH, 20'h1_0103);
    nx; flag_load_i<=1; flag_load_val_i<=16'h0100;
    nx; flag_load_i<=0; instr_done_i<=1;
    nx; instr_done_i<=0; #1 chk(trace_req_o, 1);
    nx; trace_push_done_i<=1;
    nx; trace_push_done_i<=0; #1 chk({trace_req_o, flags_o}, 0);
    wr(8'h40, 0); chk(rs, RESP_SLVERR);
    rdr(8'h40); chk(rs, RESP_SLVERR); chk(rd, 0);
    stop_test;
  end
endmodule // tb
